// File: verilog/urm_pkg.sv
// package: register map, fields, modes and role codes of the role/mode block
package urm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_MODE_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_MODE_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_EP_IRQ = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CTRL_IRQ = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_EP_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_SESSION = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PHY_PWR = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// endpoint groups: one flag per endpoint, ep0 included
	localparam int EP_W = 8;
	localparam int EP_HOST_LSB = 0;
	localparam int EP_PERIPH_LSB = 16;
	// endpoint pairs beyond ep0
	localparam logic [7:0] EP_PAIRS = 8'h07;

	localparam int CTRL_W = 12;
	localparam int CI_VBUS_ERR = 0;
	localparam int CI_SESSION = 1;
	localparam int CI_SESSION_END = 2;
	localparam int CI_DISCONNECT = 3;
	localparam int CI_CONNECT = 4;
	localparam int CI_SOF = 5;
	localparam int CI_BABBLE = 6;
	localparam int CI_RESET = 7;
	localparam int CI_RESUME = 8;
	localparam int CI_SUSPEND = 9;
	localparam int CI_MODE_DETECT = 10;
	localparam int CI_POWER_FAULT = 11;

	localparam int MODE_W = 3;
	localparam logic [MODE_W-1:0] FULL_DUAL_ROLE_SEL = 3'h0;
	localparam logic [MODE_W-1:0] FORCED_HOST_PLAIN_SEL = 3'h1;
	localparam logic [MODE_W-1:0] FORCED_HOST_SENSE_SEL = 3'h2;
	localparam logic [MODE_W-1:0] FORCED_PERIPH_PLAIN_SEL = 3'h3;
	localparam logic [MODE_W-1:0] FORCED_PERIPH_SENSE_SEL = 3'h4;

	localparam logic [2:0] ROLE_UNRESOLVED = 3'h0;
	localparam logic [2:0] ROLE_A_SIDE_HOST = 3'h1;
	localparam logic [2:0] ROLE_A_SIDE_PERIPH = 3'h2;
	localparam logic [2:0] ROLE_B_SIDE_HOST = 3'h3;
	localparam logic [2:0] ROLE_B_SIDE_PERIPH = 3'h4;
	localparam logic [2:0] ROLE_DUAL_HOST = 3'h5;
	localparam logic [2:0] ROLE_DUAL_PERIPH = 3'h6;

	localparam int STAT_ROLE_LSB = 0;
	localparam int STAT_VBUS_BIT = 4;
	localparam int STAT_ID_BIT = 5;
	localparam int STAT_LINK_BIT = 6;
	localparam int SES_START_BIT = 0;
	localparam int SES_END_BIT = 1;
	localparam int SES_SWAP_BIT = 2;
	localparam int PHY_ON_BIT = 0;

	typedef enum logic [6:0] {
		ST_NONE = 7'h01,
		ST_A_HOST = 7'h02,
		ST_A_PERIPH = 7'h04,
		ST_B_HOST = 7'h08,
		ST_B_PERIPH = 7'h10,
		ST_F_HOST = 7'h20,
		ST_F_PERIPH = 7'h40
	} urm_role_e;
endpackage : urm_pkg

// File: verilog/urm_sync.sv
// two-stage synchroniser for one pin level
`timescale 1ns/1ps
module urm_sync
	import urm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} urm_sync_s;

	urm_sync_s st;
	urm_sync_s next_st;

	always_comb begin
		next_st.s1 = srst ? 1'b0 : d;
		next_st.s2 = srst ? 1'b0 : st.s1;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign q = st.s2;
endmodule : urm_sync

// File: verilog/urm_cor_flags.sv
// sticky event flags cleared as a whole by a status read
`timescale 1ns/1ps
module urm_cor_flags
	import urm_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] set_evt,
	input wire logic clr,
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] flags;
	} urm_cor_s;

	urm_cor_s st;
	urm_cor_s next_st;

	// the reader captured the old flags; an event in the same cycle stays pending
	always_comb begin
		next_st.flags = (st.flags & ~{W{clr}}) | set_evt; // [R01] [R17] [R18]
		if (srst) begin
			next_st.flags = '0;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign flags = st.flags;
endmodule : urm_cor_flags

// File: verilog/urm_role_mode.sv
// role and mode control with endpoint/control status behind an AXI4-Lite slave
//
// Overview of operation
// [R01] endpoint status read clears all endpoint flags
// [R02] endpoint status separate from control status
// [R03] endpoint flags split into host, device groups
// [R04] dual-role mode samples VBUS and ID pins
// [R05] device role may watch VBUS for disconnect
// [R06] host role senses VBUS droop when enabled
// [R07] two forced-host modes: plain, VBUS sensing
// [R08] two forced-device modes: plain, VBUS sensing
// [R09] dual-role state: five values incl none
// [R10] session start without cable gives B-side device
// [R11] none reported when not resolving role
// [R12] forced modes report host, device or none
// [R13] endpoint pair count excludes endpoint zero
// [R14] commands start and end a session
// [R15] no operation while PHY powered off
// [R16] PHY powered on after reset
// [R17] control status read clears all control flags
// [R18] event during clearing read stays pending
// [R19] none while PHY off or role unresolved
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module urm_role_mode
	import urm_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic VBUS_PIN,
	input wire logic ID_PIN,
	input wire logic [CTRL_W-1:0] LINK_CTRL_EVT,
	input wire logic [EP_W-1:0] EP_HOST_EVT,
	input wire logic [EP_W-1:0] EP_PERIPH_EVT,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic PHY_PWR_ON,
	output logic LINK_EN,
	output logic HOST_ROLE
);
	typedef struct packed {
		urm_role_e role;
		logic [MODE_W-1:0] mode;
		logic phy_on;
		logic vbus_q;
		logic id_q;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [DATA_W-1:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic link_en;
		logic host_role;
	} urm_top_s;

	localparam urm_top_s TOP_RST = '{
		role: ST_NONE,
		mode: FULL_DUAL_ROLE_SEL,
		phy_on: 1'b1,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		default: '0
	};

	urm_top_s st;
	urm_top_s next_st;

	logic vbus_s;
	logic id_s;
	logic [2*EP_W-1:0] ep_flags;
	logic [CTRL_W-1:0] ctrl_flags;
	logic [CTRL_W-1:0] ctrl_evt;
	logic [2*EP_W-1:0] ep_evt;
	logic [CTRL_W-1:0] own_evt;
	logic rd_ep;
	logic rd_ctrl;
	logic ar_ok;
	logic aw_ok;
	logic w_ok;
	logic wr_go;
	logic wr_ok;
	logic ses_start;
	logic ses_end;
	logic ses_swap;
	logic vbus_fall;
	logic id_chg;
	logic [DATA_W-1:0] rd_data;
	logic [1:0] rd_resp;
	logic [2:0] role_code;

	urm_sync u_vbus_sync (
		.clk(CLK),
		.srst(SRST),
		.d(VBUS_PIN),
		.q(vbus_s)
	);

	urm_sync u_id_sync (
		.clk(CLK),
		.srst(SRST),
		.d(ID_PIN),
		.q(id_s)
	);

	// host group in the low half, device group in the high half
	assign ep_evt = st.link_en ? {EP_PERIPH_EVT, EP_HOST_EVT} : '0; // [R03] [R15]
	assign ctrl_evt = own_evt | (st.link_en ? LINK_CTRL_EVT : '0); // [R15]

	urm_cor_flags #(
		.W(2*EP_W)
	) u_ep_flags (
		.clk(CLK),
		.srst(SRST),
		.set_evt(ep_evt),
		.clr(rd_ep),
		.flags(ep_flags)
	);

	urm_cor_flags #(
		.W(CTRL_W)
	) u_ctrl_flags (
		.clk(CLK),
		.srst(SRST),
		.set_evt(ctrl_evt),
		.clr(rd_ctrl),
		.flags(ctrl_flags)
	);

	assign aw_ok = S_AXI_AWVALID & st.awready;
	assign w_ok = S_AXI_WVALID & st.wready;
	assign ar_ok = S_AXI_ARVALID & st.arready;
	assign wr_go = st.aw_full & st.w_full & ~st.bvalid;
	assign wr_ok = wr_go & st.w_lane0;
	// separate read paths, each clears only its own flags
	assign rd_ep = ar_ok & (S_AXI_ARADDR == REG_EP_IRQ); // [R01] [R02]
	assign rd_ctrl = ar_ok & (S_AXI_ARADDR == REG_CTRL_IRQ); // [R17] [R02]

	assign ses_start = wr_ok & (st.aw_addr == REG_SESSION) & st.w_data[SES_START_BIT]; // [R14]
	assign ses_end = wr_ok & (st.aw_addr == REG_SESSION) & st.w_data[SES_END_BIT]; // [R14]
	assign ses_swap = wr_ok & (st.aw_addr == REG_SESSION) & st.w_data[SES_SWAP_BIT];
	assign vbus_fall = st.vbus_q & ~vbus_s;
	assign id_chg = st.id_q ^ id_s;

	always_comb begin
		case (st.role)
			ST_A_HOST: role_code = ROLE_A_SIDE_HOST; // [R09]
			ST_A_PERIPH: role_code = ROLE_A_SIDE_PERIPH; // [R09]
			ST_B_HOST: role_code = ROLE_B_SIDE_HOST; // [R09]
			ST_B_PERIPH: role_code = ROLE_B_SIDE_PERIPH; // [R09]
			ST_F_HOST: role_code = ROLE_DUAL_HOST; // [R12]
			ST_F_PERIPH: role_code = ROLE_DUAL_PERIPH; // [R12]
			default: role_code = ROLE_UNRESOLVED; // [R11] [R19]
		endcase
	end

	always_comb begin
		rd_data = '0;
		rd_resp = RESP_OKAY;
		case (S_AXI_ARADDR)
			REG_MODE_CFG: rd_data[MODE_W-1:0] = st.mode;
			REG_MODE_STAT: begin
				rd_data[STAT_ROLE_LSB +: 3] = role_code;
				rd_data[STAT_VBUS_BIT] = vbus_s;
				rd_data[STAT_ID_BIT] = id_s;
				rd_data[STAT_LINK_BIT] = st.link_en;
			end
			REG_EP_IRQ: begin
				rd_data[EP_HOST_LSB +: EP_W] = ep_flags[EP_W-1:0]; // [R03]
				rd_data[EP_PERIPH_LSB +: EP_W] = ep_flags[2*EP_W-1:EP_W]; // [R03]
			end
			REG_CTRL_IRQ: rd_data[CTRL_W-1:0] = ctrl_flags;
			REG_EP_COUNT: rd_data[7:0] = EP_PAIRS; // [R13]
			REG_SESSION: rd_data = '0;
			REG_PHY_PWR: rd_data[PHY_ON_BIT] = st.phy_on;
			default: rd_resp = RESP_SLVERR;
		endcase
	end

	always_comb begin
		next_st = st;
		own_evt = '0;
		next_st.vbus_q = vbus_s; // [R04]
		next_st.id_q = id_s; // [R04]

		// write channel: address and data may arrive in either order
		if (aw_ok) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = S_AXI_AWADDR;
		end
		if (w_ok) begin
			next_st.w_full = 1'b1;
			next_st.w_data = S_AXI_WDATA;
			next_st.w_lane0 = S_AXI_WSTRB[0];
		end
		if (st.bvalid & S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			case (st.aw_addr)
				REG_MODE_CFG,
				REG_MODE_STAT,
				REG_EP_IRQ,
				REG_CTRL_IRQ,
				REG_EP_COUNT,
				REG_SESSION,
				REG_PHY_PWR: next_st.bresp = RESP_OKAY;
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end
		next_st.awready = ~next_st.aw_full;
		next_st.wready = ~next_st.w_full;

		// only fields in byte lane 0 are writable; an unknown mode is ignored
		if (wr_ok & (st.aw_addr == REG_MODE_CFG)) begin
			if (st.w_data[MODE_W-1:0] <= FORCED_PERIPH_SENSE_SEL) begin
				next_st.mode = st.w_data[MODE_W-1:0]; // [R07] [R08]
			end
		end
		if (wr_ok & (st.aw_addr == REG_PHY_PWR)) begin
			next_st.phy_on = st.w_data[PHY_ON_BIT]; // [R16]
		end

		// read channel
		if (ar_ok) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_data;
			next_st.rresp = rd_resp;
		end
		if (st.rvalid & S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end

		// role resolution
		if (!st.phy_on) begin
			next_st.role = ST_NONE; // [R15] [R19]
		end else if (next_st.mode != st.mode) begin
			next_st.role = ST_NONE;
		end else begin
			case (st.mode)
				FULL_DUAL_ROLE_SEL: begin
					case (st.role)
						ST_NONE: begin
							if (ses_start) begin
								own_evt[CI_MODE_DETECT] = 1'b1;
								if (!id_s) begin
									// ID grounded: A-plug in place
									next_st.role = ST_A_HOST; // [R04]
									own_evt[CI_SESSION] = 1'b1;
								end else begin
									// ID high also covers no cable at all
									next_st.role = ST_B_PERIPH; // [R10]
								end
							end
						end
						ST_A_HOST,
						ST_A_PERIPH: begin
							if (ses_end | id_chg) begin
								next_st.role = ST_NONE; // [R14] [R04]
							end else if (vbus_fall) begin
								next_st.role = ST_NONE;
								own_evt[CI_VBUS_ERR] = 1'b1; // [R06]
							end else if (ses_swap) begin
								next_st.role = (st.role == ST_A_HOST) ? ST_A_PERIPH : ST_A_HOST;
							end
						end
						ST_B_HOST,
						ST_B_PERIPH: begin
							if (ses_end | id_chg) begin
								next_st.role = ST_NONE; // [R14] [R04]
							end else if (vbus_fall) begin
								next_st.role = ST_NONE;
								own_evt[CI_SESSION_END] = 1'b1; // [R05]
							end else if (ses_swap) begin
								next_st.role = (st.role == ST_B_PERIPH) ? ST_B_HOST : ST_B_PERIPH;
							end
						end
						default: next_st.role = ST_NONE;
					endcase
				end
				FORCED_HOST_PLAIN_SEL: begin
					// pins are ignored entirely
					next_st.role = ST_F_HOST; // [R07]
				end
				FORCED_HOST_SENSE_SEL: begin
					next_st.role = ST_F_HOST; // [R07]
					if (st.role == ST_F_HOST) begin
						own_evt[CI_VBUS_ERR] = vbus_fall; // [R06] [R07]
					end
				end
				FORCED_PERIPH_PLAIN_SEL: begin
					next_st.role = ST_F_PERIPH; // [R08]
				end
				FORCED_PERIPH_SENSE_SEL: begin
					next_st.role = ST_F_PERIPH; // [R08]
					if (st.role == ST_F_PERIPH) begin
						own_evt[CI_SESSION_END] = vbus_fall; // [R05] [R08]
					end
				end
				default: next_st.role = ST_NONE;
			endcase
		end

		// link runs only with PHY on and a resolved role
		next_st.link_en = next_st.phy_on & (next_st.role != ST_NONE); // [R15]
		next_st.host_role = (next_st.role == ST_A_HOST) | (next_st.role == ST_B_HOST)
			| (next_st.role == ST_F_HOST);
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			st <= TOP_RST; // [R16]
		end else begin
			st <= next_st;
		end
	end

	assign S_AXI_AWREADY = st.awready;
	assign S_AXI_WREADY = st.wready;
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_BRESP = st.bresp;
	assign S_AXI_ARREADY = st.arready;
	assign S_AXI_RVALID = st.rvalid;
	assign S_AXI_RDATA = st.rdata;
	assign S_AXI_RRESP = st.rresp;
	assign PHY_PWR_ON = st.phy_on;
	assign LINK_EN = st.link_en;
	assign HOST_ROLE = st.host_role;
endmodule : urm_role_mode

// File: tb/urm_role_mode_sva.sv
// port checks of the role and mode block
`timescale 1ns/1ps
module urm_role_mode_sva
	import urm_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [DATA_W-1:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic PHY_PWR_ON,
	input wire logic LINK_EN
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	logic wr_ok;
	logic ar_ok;
	assign wr_ok = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	assign ar_ok = S_AXI_ARVALID && S_AXI_ARREADY;
	sequence s_wr_take;
		wr_ok;
	endsequence
	sequence s_wr_answer;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> s_wr_answer)
		else $error("write response late or early");
	a_rd_answer: assert property (ar_ok |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read data late");
	a_ep_count: assert property (ar_ok && S_AXI_ARADDR == REG_EP_COUNT
		|=> S_AXI_RDATA == {24'h000000, EP_PAIRS})
		else $error("endpoint pair count wrong");
	a_ep_groups: assert property (ar_ok && S_AXI_ARADDR == REG_EP_IRQ
		|=> S_AXI_RDATA[15:8] == 8'h00 && S_AXI_RDATA[31:24] == 8'h00)
		else $error("endpoint status outside its groups");
	a_bad_addr: assert property (ar_ok && S_AXI_ARADDR > REG_PHY_PWR
		|=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
		else $error("unmapped read not refused");
	a_phy_reset: assert property ($fell(SRST) |-> PHY_PWR_ON)
		else $error("phy not powered after reset");
	// link enable drops on the same edge as phy power
	a_phy_link: assert property (!PHY_PWR_ON |-> !LINK_EN)
		else $error("link enabled with phy off");
	a_phy_write: assert property (wr_ok && S_AXI_AWADDR == REG_PHY_PWR
		&& S_AXI_WSTRB[0] |-> ##2 PHY_PWR_ON == $past(S_AXI_WDATA[PHY_ON_BIT], 2))
		else $error("phy power write not applied");
endmodule : urm_role_mode_sva
bind urm_role_mode urm_role_mode_sva u_sva (.*);

// File: tb/urm_far_end.sv
// cable partner: vbus, id and link event pulses
`timescale 1ns/1ps
module urm_far_end
	import urm_pkg::*;
(
	input wire logic clk,
	output logic vbus,
	output logic id,
	output logic [CTRL_W-1:0] ctl,
	output logic [EP_W-1:0] eph,
	output logic [EP_W-1:0] epp
);
	initial begin
		vbus = 1'b0;
		id = 1'b1;
		{ctl, eph, epp} = '0;
	end
	// id stays high on a b plug or with no cable at all
	task automatic plug(input logic a_side, input logic pwr);
		@(posedge clk);
		id <= !a_side;
		vbus <= pwr;
	endtask : plug
	task automatic pulse(input logic [CTRL_W-1:0] c, input logic [EP_W-1:0] h,
		input logic [EP_W-1:0] p);
		@(posedge clk);
		{ctl, eph, epp} <= {c, h, p};
		@(posedge clk);
		{ctl, eph, epp} <= '0;
	endtask : pulse
endmodule : urm_far_end

// File: tb/urm_role_mode_bench.sv
// self-checking bench of the role and mode block
`timescale 1ns/1ps
module urm_role_mode_bench
	import urm_pkg::*;
;
	logic clk, srst, vbus, id, phy, link, host;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb;
	logic [CTRL_W-1:0] ctl;
	logic [EP_W-1:0] eph, epp;
	int miscompares = 0;
	int checked = 0;
	urm_role_mode dut (.CLK(clk), .SRST(srst), .VBUS_PIN(vbus), .ID_PIN(id),
		.LINK_CTRL_EVT(ctl), .EP_HOST_EVT(eph), .EP_PERIPH_EVT(epp),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PHY_PWR_ON(phy),
		.LINK_EN(link), .HOST_ROLE(host));
	urm_far_end far (.clk(clk), .vbus(vbus), .id(id), .ctl(ctl), .eph(eph), .epp(epp));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic lim(input int n);
		if (n >= 50) begin
			miscompares++;
			$display("[FAIL] %0t bus wait ran out", $time);
			test_done();
		end
	endtask : lim
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while ((awvalid && !awready || wvalid && !wready) && n < 50);
		while (bvalid !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		bready <= 1'b0;
		lim(n);
		cmp(32'(bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		rready <= 1'b0;
		lim(n);
		cmp(rdata & m, e);
		cmp(32'(rresp), 32'(er));
	endtask : rd
	task automatic t_reset();
		rd(REG_MODE_CFG, 32'h0, '1);
		rd(REG_PHY_PWR, 32'h1, '1);
		rd(REG_MODE_STAT, 32'h0, 32'h7);
		rd(REG_EP_COUNT, 32'(EP_W - 1), '1);
		rd(8'h1C, 32'h0, '1, RESP_SLVERR);
		wr(8'h1C, 32'h1, RESP_SLVERR);
	endtask : t_reset
	task automatic t_forced();
		logic [2:0] r;
		logic [31:0] e;
		for (int m = 1; m <= 4; m++) begin
			r = (m < 3) ? ROLE_DUAL_HOST : ROLE_DUAL_PERIPH;
			e = (m == 2) ? 32'h1 : (m == 4) ? 32'h4 : 32'h0;
			far.plug(1'b0, 1'b1);
			wr(REG_MODE_CFG, 32'(m));
			repeat (8) @(posedge clk);
			rd(REG_CTRL_IRQ, 32'h0, 32'h0);
			rd(REG_MODE_STAT, {29'h0, r}, 32'h7);
			cmp(32'(host), 32'(m < 3));
			far.plug(1'b0, 1'b0);
			repeat (8) @(posedge clk);
			rd(REG_CTRL_IRQ, e, 32'h5);
			rd(REG_MODE_STAT, {29'h0, r}, 32'h7);
		end
	endtask : t_forced
	task automatic t_ep();
		rd(REG_CTRL_IRQ, 32'h0, 32'h0);
		far.pulse('0, 8'h08, 8'h20);
		rd(REG_EP_IRQ, 32'h00200008, '1);
		rd(REG_EP_IRQ, 32'h0, '1);
		for (int i = 0; i < CTRL_W; i++) begin
			far.pulse(12'h1 << i, '0, '0);
			rd(REG_CTRL_IRQ, 32'h1 << i, '1);
			rd(REG_CTRL_IRQ, 32'h0, '1);
		end
		far.pulse(12'h020, 8'h01, '0);
		rd(REG_EP_IRQ, 32'h1, '1);
		rd(REG_CTRL_IRQ, 32'h20, '1);
		// event lands on the very edge that takes the clearing read
		fork
			far.pulse('0, 8'h80, '0);
			rd(REG_EP_IRQ, 32'h0, '1);
		join
		rd(REG_EP_IRQ, 32'h80, '1);
	endtask : t_ep
	task automatic t_phy();
		wr(REG_PHY_PWR, 32'h0);
		repeat (4) @(posedge clk);
		cmp(32'(phy), 32'h0);
		cmp(32'(link), 32'h0);
		rd(REG_MODE_STAT, 32'h0, 32'h7);
		far.pulse('0, 8'h01, 8'h01);
		rd(REG_EP_IRQ, 32'h0, '1);
		wr(REG_PHY_PWR, 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, {29'h0, ROLE_DUAL_PERIPH}, 32'h7);
		cmp(32'(link), 32'h1);
		wr(REG_MODE_CFG, 32'h7);
		rd(REG_MODE_CFG, 32'h4, '1);
		// lane 0 not strobed: the mode field must stay as it was
		wr(REG_MODE_CFG, 32'h1, RESP_OKAY, 4'hE);
		rd(REG_MODE_CFG, 32'h4, '1);
	endtask : t_phy
	task automatic t_dual();
		wr(REG_MODE_CFG, 32'h0);
		repeat (8) @(posedge clk);
		rd(REG_MODE_STAT, 32'h20, 32'h37);
		wr(REG_SESSION, 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, {29'h0, ROLE_B_SIDE_PERIPH}, 32'h7);
		wr(REG_SESSION, 32'h4);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, {29'h0, ROLE_B_SIDE_HOST}, 32'h7);
		cmp(32'(host), 32'h1);
		wr(REG_SESSION, 32'h2);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, 32'h0, 32'h7);
		far.plug(1'b1, 1'b1);
		repeat (8) @(posedge clk);
		rd(REG_CTRL_IRQ, 32'h0, 32'h0);
		wr(REG_SESSION, 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, {26'h0, 3'h2, ROLE_A_SIDE_HOST}, 32'h37);
		rd(REG_CTRL_IRQ, 32'h402, 32'h402);
		wr(REG_SESSION, 32'h4);
		repeat (4) @(posedge clk);
		rd(REG_MODE_STAT, {29'h0, ROLE_A_SIDE_PERIPH}, 32'h7);
		far.plug(1'b1, 1'b0);
		repeat (8) @(posedge clk);
		rd(REG_MODE_STAT, 32'h0, 32'h7);
		rd(REG_CTRL_IRQ, 32'h1, 32'h1);
		// b plug with vbus: losing vbus must end the session
		far.plug(1'b0, 1'b1);
		repeat (8) @(posedge clk);
		wr(REG_SESSION, 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_CTRL_IRQ, 32'h0, 32'h0);
		rd(REG_MODE_STAT, {29'h0, ROLE_B_SIDE_PERIPH}, 32'h7);
		far.plug(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		rd(REG_MODE_STAT, 32'h0, 32'h7);
		rd(REG_CTRL_IRQ, 32'h4, 32'h5);
	endtask : t_dual
	initial begin
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = '0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_forced();
		t_ep();
		t_phy();
		t_dual();
		test_done();
	end
endmodule : urm_role_mode_bench
